/* inc/crs_consts.vh */
// Constants for the channel request status and host service block
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_MCR_OFS 12'h000
`define CRS_GLB_PAGE 4'h2
`define CRS_GSEL_IRQ_STAT 3'h0
`define CRS_GSEL_IRQ_OVF 3'h1
`define CRS_GSEL_XFER_STAT 3'h2
`define CRS_GSEL_XFER_OVF 3'h3
`define CRS_GSEL_IRQ_EN 3'h4
`define CRS_GSEL_XFER_EN 3'h5
`define CRS_CHAN_PAGE_A 2'h1
`define CRS_CHAN_PAGE_B 2'h2
`define CRS_CFG_WORD 2'h0
`define CRS_SCR_WORD 2'h1
`define CRS_HSR_WORD 2'h2
`define CRS_CFG_IRQ_EN 0
`define CRS_CFG_XFER_EN 1
`define CRS_SCR_IRQ_PEND 0
`define CRS_SCR_IRQ_OVF 1
`define CRS_SCR_XFER_PEND 8
`define CRS_SCR_XFER_OVF 9
`define CRS_SCR_IN_PIN 16
`define CRS_SCR_OUT_PIN 17
`define CRS_SCR_OUT_BUF 18
`define CRS_SCR_FMODE_LO 30
`define CRS_HSR_LO 29
`define CRS_MCR_SIG_EN 8
`define CRS_MCR_GLB_EXC 16
`define CRS_MCR_GEC 31
`define CRS_DMA_MASK_A 32'h3000f007
`define CRS_DMA_MASK_B 32'hf000f00f
`define CRS_HSR_IDLE 3'h0
`endif

/* hw/crs_host_service.v */
// Channel interrupt, transfer request, host service and global exception logic
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_host_service (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [63:0] irqRaise,
    input wire [63:0] xferRaise,
    input wire [63:0] inPinState,
    input wire [63:0] outPinState,
    input wire [63:0] outBufEnable,
    input wire [63:0] svcResolve,
    input wire [63:0] svcDone,
    input wire illegalInstrA,
    input wire illegalInstrB,
    input wire sigMismatch,
    input wire microExcA,
    input wire microExcB,
    output reg [63:0] chanIrq,
    output reg [63:0] xferReq,
    output reg globalException,
    output wire [191:0] hostSvcCode,
    output wire [127:0] fnMode
);

////////////////////////////////////////////////////////////////////////////////
// Address decoding

// Returns {hit, engine and channel index}
function [6:0] crsChanDec;
    input [11:0] a;
    begin
        crsChanDec = {((a[11:10] == `CRS_CHAN_PAGE_A) || (a[11:10] == `CRS_CHAN_PAGE_B)) && !a[9],
                      a[11], a[8:4]};
    end
endfunction

// Returns {hit, global register select}
function [3:0] crsGlobDec;
    input [11:0] a;
    begin
        crsGlobDec = {(a[11:8] == `CRS_GLB_PAGE) && !a[3] && (a[6:4] <= `CRS_GSEL_XFER_EN), a[6:4]};
    end
endfunction

// Picks the half of a channel vector that belongs to one engine
function [31:0] crsHalf;
    input [63:0] v;
    input e;
    begin
        crsHalf = e ? v[63:32] : v[31:0];
    end
endfunction

reg [63:0] irqPend;
reg [63:0] irqOvf;
reg [63:0] xferPend;
reg [63:0] xferOvf;
reg [63:0] irqEn;
reg [63:0] xferEn;
reg [63:0] inSyncA;
reg [63:0] inSyncB;
reg [4:0] excFlag;
reg sigChkEn;
reg [31:0] rdVal;

wire [6:0] chDec = crsChanDec(paddr);
wire [3:0] glDec = crsGlobDec(paddr);
wire chHit = chDec[6];
wire [5:0] chIdx = chDec[5:0];
wire [1:0] chWord = paddr[3:2];
wire glHit = glDec[3];
wire [2:0] glSel = glDec[2:0];
wire glEng = paddr[2];
wire mcrHit = (paddr == `CRS_MCR_OFS);
wire mapped = chHit | glHit | mcrHit;

wire apbSetup = psel & ~penable;
wire wrEn = psel & penable & pready & pwrite & mapped;

////////////////////////////////////////////////////////////////////////////////
// Write masks, one bit per channel

wire [63:0] chSel = 64'h1 << chIdx;
wire [63:0] chWr = (wrEn & chHit) ? chSel : 64'h0;
wire [63:0] cfgWr = chWr & {64{chWord == `CRS_CFG_WORD}};
wire [63:0] scrWr = chWr & {64{chWord == `CRS_SCR_WORD}};
wire [63:0] hsrWr = chWr & {64{chWord == `CRS_HSR_WORD}};
wire [63:0] halfSel = glEng ? {32'hffffffff, 32'h0} : {32'h0, 32'hffffffff};
wire [63:0] gData = glEng ? {pwdata, 32'h0} : {32'h0, pwdata};
wire glWr = wrEn & glHit;

// Writes of one clear; zeros have no say
wire [63:0] irqClr = (scrWr & {64{pwdata[`CRS_SCR_IRQ_PEND]}}) |
    ((glWr && glSel == `CRS_GSEL_IRQ_STAT) ? gData : 64'h0);
wire [63:0] irqOvfClr = (scrWr & {64{pwdata[`CRS_SCR_IRQ_OVF]}}) |
    ((glWr && glSel == `CRS_GSEL_IRQ_OVF) ? gData : 64'h0);
wire [63:0] xferClr = (scrWr & {64{pwdata[`CRS_SCR_XFER_PEND]}}) |
    ((glWr && glSel == `CRS_GSEL_XFER_STAT) ? gData : 64'h0);
wire [63:0] xferOvfClr = (scrWr & {64{pwdata[`CRS_SCR_XFER_OVF]}}) |
    ((glWr && glSel == `CRS_GSEL_XFER_OVF) ? gData : 64'h0);

wire [63:0] irqEnMask = cfgWr | ((glWr && glSel == `CRS_GSEL_IRQ_EN) ? halfSel : 64'h0);
wire [63:0] irqEnVal = (cfgWr & {64{pwdata[`CRS_CFG_IRQ_EN]}}) |
    ((glWr && glSel == `CRS_GSEL_IRQ_EN) ? gData : 64'h0);
wire [63:0] xferEnMask = cfgWr | ((glWr && glSel == `CRS_GSEL_XFER_EN) ? halfSel : 64'h0);
wire [63:0] xferEnVal = (cfgWr & {64{pwdata[`CRS_CFG_XFER_EN]}}) |
    ((glWr && glSel == `CRS_GSEL_XFER_EN) ? gData : 64'h0);

////////////////////////////////////////////////////////////////////////////////
// Next state of status, overflow and enables

// Only microcode request events set status; a set in the clearing cycle wins
wire [63:0] next_irqPend = (irqPend & ~irqClr) | irqRaise;
wire [63:0] next_xferPend = (xferPend & ~xferClr) | xferRaise;
wire [63:0] next_irqOvf = (irqOvf & ~irqOvfClr) | (irqRaise & irqPend);
wire [63:0] next_xferOvf = (xferOvf & ~xferOvfClr) | (xferRaise & xferPend);
wire [63:0] next_irqEn = (irqEn & ~irqEnMask) | irqEnVal;
wire [63:0] next_xferEn = (xferEn & ~xferEnMask) | xferEnVal;

wire gecWr = wrEn & mcrHit & pwdata[`CRS_MCR_GEC];
wire [4:0] excSet = {microExcB, microExcA, sigMismatch & sigChkEn, illegalInstrB, illegalInstrA};
// Flags are plain set/clear bits, so repeats leave no extra record
wire [4:0] next_excFlag = (excFlag & ~{5{gecWr}}) | excSet;

always @(posedge clock) begin
    if (!rst_n) begin
        irqPend <= 64'h0;
        irqOvf <= 64'h0;
        xferPend <= 64'h0;
        xferOvf <= 64'h0;
        irqEn <= 64'h0;
        xferEn <= 64'h0;
        excFlag <= 5'h0;
        sigChkEn <= 1'b0;
        chanIrq <= 64'h0;
        xferReq <= 64'h0;
        globalException <= 1'b0;
    end else begin
        irqPend <= next_irqPend;
        irqOvf <= next_irqOvf;
        xferPend <= next_xferPend;
        xferOvf <= next_xferOvf;
        irqEn <= next_irqEn;
        xferEn <= next_xferEn;
        excFlag <= next_excFlag;
        if (wrEn & mcrHit) begin
            sigChkEn <= pwdata[`CRS_MCR_SIG_EN];
        end
        chanIrq <= next_irqPend & next_irqEn;
        xferReq <= next_xferPend & next_xferEn & {`CRS_DMA_MASK_B, `CRS_DMA_MASK_A};
        globalException <= |next_excFlag;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Input pin synchroniser

always @(posedge clock) begin
    if (!rst_n) begin
        inSyncA <= 64'h0;
        inSyncB <= 64'h0;
    end else begin
        inSyncA <= inPinState;
        inSyncB <= inSyncA;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-channel host service code and function mode

wire [63:0] svcLocked;

genvar g;
generate
    for (g = 0; g < 64; g = g + 1) begin : gChan
        reg [2:0] code;
        reg locked;
        reg [1:0] mode;
        wire resolving = svcResolve[g] & (code != `CRS_HSR_IDLE);
        always @(posedge clock) begin
            if (!rst_n) begin
                code <= `CRS_HSR_IDLE;
                locked <= 1'b0;
                mode <= 2'h0;
            end else begin
                if (svcDone[g]) begin
                    code <= `CRS_HSR_IDLE;
                    locked <= 1'b0;
                end else if (resolving) begin
                    locked <= 1'b1;
                end else if (hsrWr[g] && !locked) begin
                    code <= pwdata[`CRS_HSR_LO +: 3];
                end
                if (scrWr[g]) begin
                    mode <= pwdata[`CRS_SCR_FMODE_LO +: 2];
                end
            end
        end
        assign hostSvcCode[g*3 +: 3] = code;
        assign fnMode[g*2 +: 2] = mode;
        assign svcLocked[g] = locked;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read data

always @* begin
    rdVal = 32'h0;
    if (chHit) begin
        case (chWord)
            `CRS_CFG_WORD: begin
                rdVal[`CRS_CFG_IRQ_EN] = irqEn[chIdx];
                rdVal[`CRS_CFG_XFER_EN] = xferEn[chIdx];
            end
            `CRS_SCR_WORD: begin
                rdVal[`CRS_SCR_IRQ_PEND] = irqPend[chIdx];
                rdVal[`CRS_SCR_IRQ_OVF] = irqOvf[chIdx];
                rdVal[`CRS_SCR_XFER_PEND] = xferPend[chIdx];
                rdVal[`CRS_SCR_XFER_OVF] = xferOvf[chIdx];
                rdVal[`CRS_SCR_IN_PIN] = inSyncB[chIdx];
                rdVal[`CRS_SCR_OUT_PIN] = outPinState[chIdx];
                rdVal[`CRS_SCR_OUT_BUF] = outBufEnable[chIdx];
                rdVal[`CRS_SCR_FMODE_LO +: 2] = fnMode[chIdx*2 +: 2];
            end
            `CRS_HSR_WORD: begin
                rdVal[`CRS_HSR_LO +: 3] = hostSvcCode[chIdx*3 +: 3];
            end
            default: begin
                rdVal = 32'h0;
            end
        endcase
    end else if (glHit) begin
        case (glSel)
            `CRS_GSEL_IRQ_STAT: rdVal = crsHalf(irqPend, glEng);
            `CRS_GSEL_IRQ_OVF: rdVal = crsHalf(irqOvf, glEng);
            `CRS_GSEL_XFER_STAT: rdVal = crsHalf(xferPend, glEng);
            `CRS_GSEL_XFER_OVF: rdVal = crsHalf(xferOvf, glEng);
            `CRS_GSEL_IRQ_EN: rdVal = crsHalf(irqEn, glEng);
            `CRS_GSEL_XFER_EN: rdVal = crsHalf(xferEn, glEng);
            default: rdVal = 32'h0;
        endcase
    end else if (mcrHit) begin
        rdVal[4:0] = excFlag;
        rdVal[`CRS_MCR_SIG_EN] = sigChkEn;
        rdVal[`CRS_MCR_GLB_EXC] = globalException;
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave: one access cycle, data captured in the setup cycle

always @(posedge clock) begin
    if (!rst_n) begin
        prdata <= 32'h0;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= apbSetup;
        pslverr <= apbSetup & ~mapped;
        if (apbSetup) begin
            prdata <= mapped ? rdVal : 32'h0;
        end
    end
end

endmodule // crs_host_service

/* verif/crs_host_service_checker.sv */
// Concurrent checks on the host service block ports
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_host_service_checker (
    input wire clock,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire [63:0] irqRaise,
    input wire [63:0] svcDone,
    input wire illegalInstrA,
    input wire [63:0] chanIrq,
    input wire [63:0] xferReq,
    input wire globalException,
    input wire [191:0] hostSvcCode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire hostWrite = psel && penable && pwrite;
    wire excClear = hostWrite && paddr == `CRS_MCR_OFS && pwdata[`CRS_MCR_GEC];
    sequence s_setup;
        psel && !penable;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> pready) else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held too long");
    a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_irq_rise_cause: assert property ($rose(chanIrq[0]) |-> $past(irqRaise[0]) || $past(hostWrite))
        else $error("interrupt rose without raise");
    a_irq_fall_cause: assert property ($fell(chanIrq[0]) |-> $past(hostWrite))
        else $error("interrupt fell without write");
    a_dma_mask_only: assert property ((xferReq & ~{`CRS_DMA_MASK_B, `CRS_DMA_MASK_A}) == 64'h0)
        else $error("unconnected channel drives transfer request");
    a_svc_done_clear: assert property (svcDone[0] |=> hostSvcCode[2:0] == 3'h0)
        else $error("service code not cleared");
    a_exc_set_flag: assert property (illegalInstrA |=> globalException)
        else $error("global exception not raised");
    a_exc_hold_clear: assert property (globalException && !excClear |=> globalException)
        else $error("global exception dropped without clear");
endmodule // crs_host_service_checker
bind crs_host_service crs_host_service_checker i_crs_host_service_checker (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .irqRaise(irqRaise), .svcDone(svcDone), .illegalInstrA(illegalInstrA),
    .chanIrq(chanIrq), .xferReq(xferReq), .globalException(globalException), .hostSvcCode(hostSvcCode));

/* verif/crs_engine_model.sv */
// Microengine event source: request raises, service steps, exceptions
`timescale 1ns/1ps
module crs_engine_model (
    input wire clock,
    output logic [63:0] irqRaise,
    output logic [63:0] xferRaise,
    output logic [63:0] svcResolve,
    output logic [63:0] svcDone,
    output logic [4:0] excSrc
);
    initial begin
        {irqRaise, xferRaise, svcResolve, svcDone, excSrc} = '0;
    end
    // One-cycle event: 0 irq, 1 transfer, 2 resolve, 3 done, 4 exception source
    task pulse(input int kind, input int idx);
        @(posedge clock);
        case (kind)
            0: irqRaise <= 64'h1 << idx;
            1: xferRaise <= 64'h1 << idx;
            2: svcResolve <= 64'h1 << idx;
            3: svcDone <= 64'h1 << idx;
            default: excSrc <= 5'h1 << idx;
        endcase
        @(posedge clock);
        {irqRaise, xferRaise, svcResolve, svcDone, excSrc} <= '0;
    endtask
endmodule // crs_engine_model

/* verif/crs_host_service_tb.sv */
// Self-checking bench for the host service block
`timescale 1ns/1ps
module crs_host_service_tb;
    logic clock, rst_n, psel, penable, pwrite, lastErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdata;
    logic [63:0] inPinState, outPinState, outBufEnable, irqRaise, xferRaise, svcResolve, svcDone;
    logic [4:0] excSrc;
    wire [31:0] prdata;
    wire pready, pslverr, globalException;
    wire [63:0] chanIrq, xferReq;
    wire [191:0] hostSvcCode;
    wire [127:0] fnMode;
    int failures = 0, checks = 0, cycles = 0;
    crs_host_service i_crs_host_service (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irqRaise(irqRaise), .xferRaise(xferRaise), .inPinState(inPinState), .outPinState(outPinState),
        .outBufEnable(outBufEnable), .svcResolve(svcResolve), .svcDone(svcDone), .illegalInstrA(excSrc[0]),
        .illegalInstrB(excSrc[1]), .sigMismatch(excSrc[2]), .microExcA(excSrc[3]), .microExcB(excSrc[4]),
        .chanIrq(chanIrq), .xferReq(xferReq), .globalException(globalException), .hostSvcCode(hostSvcCode),
        .fnMode(fnMode));
    crs_engine_model i_crs_engine_model (.clock(clock), .irqRaise(irqRaise), .xferRaise(xferRaise),
        .svcResolve(svcResolve), .svcDone(svcDone), .excSrc(excSrc));
    ////////////////////////////////////////////////////////////////
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, pready, 1'b1);
        end
        rdata = prdata;
        lastErr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task test_done;
        $display("Counts: %0d checks, %0d failures", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task test_status;
        wr(12'h400, 32'h3);
        wr(12'h430, 32'h2);
        rd(12'h240, 32'h1);
        rd(12'h250, 32'h9);
        i_crs_engine_model.pulse(0, 0);
        i_crs_engine_model.pulse(0, 0);
        rd(12'h404, 32'h3);
        check({31'h0, chanIrq[0]}, 32'h1);
        wr(12'h404, 32'h0);
        rd(12'h404, 32'h3);
        wr(12'h404, 32'h1);
        rd(12'h404, 32'h2);
        check({31'h0, chanIrq[0]}, 32'h0);
        wr(12'h404, 32'h2);
        rd(12'h404, 32'h0);
        i_crs_engine_model.pulse(1, 3);
        i_crs_engine_model.pulse(1, 0);
        rd(12'h434, 32'h100);
        check({31'h0, xferReq[3]}, 32'h0);
        check({31'h0, xferReq[0]}, 32'h1);
        rd(12'h220, 32'h9);
        wr(12'h220, 32'h8);
        rd(12'h434, 32'h0);
        $display("test_status done");
    endtask
    task test_fields;
        wr(12'h414, 32'hffffffff);
        rd(12'h414, 32'hc0070000);
        check({30'h0, fnMode[3:2]}, 32'h3);
        rd(12'h600, 32'h0);
        check({31'h0, lastErr}, 32'h1);
        $display("test_fields done");
    endtask
    task test_service;
        wr(12'h408, 32'h60000000);
        rd(12'h408, 32'h60000000);
        check({29'h0, hostSvcCode[2:0]}, 32'h3);
        i_crs_engine_model.pulse(2, 0);
        wr(12'h408, 32'h0);
        rd(12'h408, 32'h60000000);
        i_crs_engine_model.pulse(3, 0);
        rd(12'h408, 32'h0);
        wr(12'h408, 32'hffffffff);
        rd(12'h408, 32'he0000000);
        wr(12'h408, 32'h0);
        rd(12'h408, 32'h0);
        $display("test_service done");
    endtask
    task test_exception;
        wr(12'h000, 32'h100);
        for (int i = 0; i < 5; i++) i_crs_engine_model.pulse(4, i);
        i_crs_engine_model.pulse(4, 0);
        rd(12'h000, 32'h0001011f);
        check({31'h0, globalException}, 32'h1);
        wr(12'h000, 32'h80000100);
        rd(12'h000, 32'h100);
        check({31'h0, globalException}, 32'h0);
        $display("test_exception done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done;
        end
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        inPinState = 64'h2;
        outPinState = 64'h2;
        outBufEnable = 64'h2;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        test_status;
        test_fields;
        test_service;
        test_exception;
        test_done;
    end
endmodule // crs_host_service_tb
